// File: dv/ppf_sensor_model.sv
// Purpose: process sensors and terminal levels seen by the feedback path
// Assumes: all channels are same-clock levels in 0.1 % units
// Notes: each channel sits 100 times its source code above base so a wrong pick shows
`timescale 1ns/1ps
module ppf_sensor_model (
  input wire logic [15:0] base,
  output logic [15:0] knob,
  output logic [15:0] ain_one,
  output logic [15:0] ain_two,
  output logic [15:0] pulse,
  output logic [15:0] link,
  output logic [15:0] card,
  output logic [15:0] current
);
  // distinct per channel, never the keypad value, so setpoint and feedback differ
  assign knob = base + 16'h0064;
  assign ain_one = base + 16'h00C8;
  assign ain_two = base + 16'h012C;
  assign pulse = base + 16'h01F4;
  assign link = base + 16'h0258;
  assign card = base + 16'h02BC;
  assign current = base + 16'h0384;
endmodule : ppf_sensor_model

// File: dv/tb_top.sv
// Purpose: self-checking bench for the feedback path and run control
// Assumes: short tick parameters, APB slave answering without wait states
// Notes: every scenario is its own task; feedback shows through FB_DISPLAY
`timescale 1ns/1ps
`include "ppf_consts.svh"
module tb_top import ppf_pkg::*;;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [15:0] PADDR = 16'h0000;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [2:0] TERM_SEL = 3'h0;
  logic [15:0] base = 16'h0032;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, PRESET_ACTIVE, HOLD_ACTIVE;
  logic [15:0] KNOB_VALUE, ANALOG_INPUT_ONE, ANALOG_INPUT_TWO, PULSE_TRAIN_INPUT, LINK_VALUE;
  logic [15:0] CARD_VALUE, ACTIVE_CURRENT, PID_OUT, FREQ_REF, FB_DISPLAY, DERIV_TERM;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] r;
  logic e;

  // ticks shortened so a whole run stays brief
  ppf_top #(.FILT_TICK_CYC(10), .PRESET_TICK_CYC(20)) u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .KNOB_VALUE(KNOB_VALUE), .ANALOG_INPUT_ONE(ANALOG_INPUT_ONE),
    .ANALOG_INPUT_TWO(ANALOG_INPUT_TWO), .PULSE_TRAIN_INPUT(PULSE_TRAIN_INPUT), .LINK_VALUE(LINK_VALUE),
    .CARD_VALUE(CARD_VALUE), .ACTIVE_CURRENT(ACTIVE_CURRENT), .TERM_SEL(TERM_SEL), .PID_OUT(PID_OUT),
    .FREQ_REF(FREQ_REF), .FB_DISPLAY(FB_DISPLAY), .DERIV_TERM(DERIV_TERM),
    .PRESET_ACTIVE(PRESET_ACTIVE), .HOLD_ACTIVE(HOLD_ACTIVE));
  ppf_sensor_model u_sensors (.base(base), .knob(KNOB_VALUE), .ain_one(ANALOG_INPUT_ONE),
    .ain_two(ANALOG_INPUT_TWO), .pulse(PULSE_TRAIN_INPUT), .link(LINK_VALUE), .card(CARD_VALUE),
    .current(ACTIVE_CURRENT));

  // 25 MHz
  always #20 REF_CLK = ~REF_CLK;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one APB transfer; request held until PREADY is sampled high
  task apb(input logic wr, input logic [13:0] idx, input logic [15:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= {16'h0000, d};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task rd_chk(input logic [13:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    check(r, {16'h0000, exp});
    check({31'h0, e}, 32'h0);
  endtask : rd_chk

  // expected feedback for a source code, keypad at its default
  function logic [15:0] chan(input logic [3:0] sel);
    return (sel == 4'h0) ? 16'h01F4 : (sel == 4'h4) ? 16'h0000 : base + 16'h0064 * {12'h000, sel};
  endfunction : chan

  task t_reset_values;
    for (int s = 0; s < 10; s++) rd_chk(`PPF_IDX_KEYPAD + 14'(s), PPF_RST[s]);
    rd_chk(`PPF_IDX_SRC, 16'h0002);
    rd_chk(`PPF_IDX_RUN, 16'h0000);
    rd_chk(`PPF_IDX_MAXF, `PPF_RST_MAXF);
    apb(1'b1, 14'h0D30, 16'h1234);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 14'h0D30, 16'h0000);
    check(r, 32'h0);
  endtask : t_reset_values

  task t_sources;
    apb(1'b1, `PPF_IDX_RAMP, 16'h0000);
    apb(1'b1, `PPF_IDX_FILT, 16'h0000);
    for (int s = 0; s < 10; s++) begin
      if (s != 8) begin
        apb(1'b1, `PPF_IDX_SRC, 16'(s));
        repeat (30) @(posedge REF_CLK);
        check(FB_DISPLAY, chan(4'(s)));
      end
    end
    // terminal-selected channel, code from terminals 3,2,1
    apb(1'b1, `PPF_IDX_SRC, 16'h0008);
    for (int t = 0; t < 8; t++) begin
      TERM_SEL <= 3'(t);
      repeat (30) @(posedge REF_CLK);
      check(FB_DISPLAY, chan(4'(t)));
    end
  endtask : t_sources

  task t_gain_range;
    apb(1'b1, `PPF_IDX_SRC, 16'h0002);
    apb(1'b1, `PPF_IDX_GAIN, 16'h00C8);
    repeat (30) @(posedge REF_CLK);
    check(FB_DISPLAY, 16'h01F4);
    apb(1'b1, `PPF_IDX_RANGE, 16'h01F4);
    repeat (30) @(posedge REF_CLK);
    check(FB_DISPLAY, 16'h00FA);
    apb(1'b1, `PPF_IDX_GAIN, 16'h0064);
    apb(1'b1, `PPF_IDX_RANGE, 16'h03E8);
  endtask : t_gain_range

  task t_filter;
    apb(1'b1, `PPF_IDX_FILT, 16'h0005);
    base <= 16'h0226;
    repeat (25) @(posedge REF_CLK);
    check({31'h0, FB_DISPLAY > 16'h00FA && FB_DISPLAY < 16'h02EE}, 32'h1);
    apb(1'b1, `PPF_IDX_FILT, 16'h0000);
    repeat (30) @(posedge REF_CLK);
    check(FB_DISPLAY, 16'h02EE);
    base <= 16'h0258;
  endtask : t_filter

  task t_preset_hold;
    apb(1'b1, `PPF_IDX_DBAND, 16'h03E8);
    apb(1'b1, `PPF_IDX_PRESET, 16'h0258);
    apb(1'b1, `PPF_IDX_DUR, 16'h0002);
    apb(1'b1, `PPF_IDX_RUN, 16'h0001);
    repeat (3) @(posedge REF_CLK);
    check({31'h0, PRESET_ACTIVE}, 32'h1);
    check(PID_OUT, 16'h0258);
    check(FREQ_REF, 16'h0BB8);
    rd_chk(`PPF_IDX_STAT, 16'h0658);
    repeat (50) @(posedge REF_CLK);
    check({31'h0, PRESET_ACTIVE}, 32'h0);
    repeat (30) @(posedge REF_CLK);
    check({31'h0, HOLD_ACTIVE}, 32'h1);
    check(PID_OUT, 16'h0258);
    rd_chk(`PPF_IDX_STAT, 16'h1A58);
  endtask : t_preset_hold

  // feedback 800 above setpoint 500: direction decides the way out moves
  task t_direction;
    apb(1'b1, `PPF_IDX_DBAND, 16'h0000);
    apb(1'b1, `PPF_IDX_CTL, 16'h0000);
    repeat (30) @(posedge REF_CLK);
    check({31'h0, PID_OUT < 16'h0258}, 32'h1);
    check({31'h0, HOLD_ACTIVE}, 32'h0);
    apb(1'b1, `PPF_IDX_CTL, 16'h0001);
    repeat (300) @(posedge REF_CLK);
    check(PID_OUT, 16'h03E8);
    check(FREQ_REF, 16'h1388);
    apb(1'b1, `PPF_IDX_RUN, 16'h0000);
    repeat (3) @(posedge REF_CLK);
    check(PID_OUT, 16'h0000);
  endtask : t_direction

  // wait for the next derivative update that is not zero, at most lim cycles
  task wait_deriv(input int lim);
    for (int i = 0; i < lim && DERIV_TERM == 16'h0000; i++) @(posedge REF_CLK);
  endtask : wait_deriv

  // feedback rises by 20: on feedback the derivative is +20, on deviation -20
  task t_deriv;
    apb(1'b1, `PPF_IDX_CTL, 16'h1000);
    repeat (30) @(posedge REF_CLK);
    check(DERIV_TERM, 16'h0000);
    base <= 16'h026C;
    wait_deriv(40);
    check(DERIV_TERM, 16'h0014);
    // reserved digits set on purpose, they must change nothing
    apb(1'b1, `PPF_IDX_CTL, 16'h0110);
    repeat (30) @(posedge REF_CLK);
    check(DERIV_TERM, 16'h0000);
    base <= 16'h0280;
    wait_deriv(40);
    check(DERIV_TERM, 16'hFFEC);
  endtask : t_deriv

  // ramp seen as +1 pulses on the deviation derivative, one per ramp unit
  task t_ramp;
    int n;
    repeat (20) @(posedge REF_CLK);
    apb(1'b1, `PPF_IDX_RAMP, 16'h0001);
    apb(1'b1, `PPF_IDX_KEYPAD, 16'h0200);
    wait_deriv(300);
    check(DERIV_TERM, 16'h0001);
    n = 0;
    while (DERIV_TERM != 16'h0000 && n < 40) begin
      n++;
      @(posedge REF_CLK);
    end
    while (DERIV_TERM == 16'h0000 && n < 400) begin
      n++;
      @(posedge REF_CLK);
    end
    check(n, `PPF_RAMP_CYC);
    check(DERIV_TERM, 16'h0001);
  endtask : t_ramp

  task summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    repeat (3) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(posedge REF_CLK);
    t_reset_values();
    t_sources();
    t_gain_range();
    t_filter();
    t_preset_hold();
    t_direction();
    t_deriv();
    t_ramp();
    summarize();
  end

  // whole run needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge REF_CLK);
    errors++;
    summarize();
  end
endmodule : tb_top

// File: src/ppf_consts.svh
// Purpose: offsets, field positions, reset values and timing figures of the feedback path
// Assumes: register byte address is four times the word index
// Notes: percentages in 0.1 % units, 1000 is full scale
`ifndef PPF_CONSTS_SVH
`define PPF_CONSTS_SVH
// word indices
`define PPF_IDX_KEYPAD 14'h0D01
`define PPF_IDX_RAMP 14'h0D02
`define PPF_IDX_SRC 14'h0D03
`define PPF_IDX_FILT 14'h0D04
`define PPF_IDX_GAIN 14'h0D05
`define PPF_IDX_RANGE 14'h0D06
`define PPF_IDX_CTL 14'h0D07
`define PPF_IDX_PRESET 14'h0D08
`define PPF_IDX_DUR 14'h0D09
`define PPF_IDX_DBAND 14'h0D0A
`define PPF_IDX_RUN 14'h0D20
`define PPF_IDX_MAXF 14'h0D21
`define PPF_IDX_STAT 14'h0D22
// storage slots
`define PPF_SLOT_KEYPAD 0
`define PPF_SLOT_RAMP 1
`define PPF_SLOT_SRC 2
`define PPF_SLOT_FILT 3
`define PPF_SLOT_GAIN 4
`define PPF_SLOT_RANGE 5
`define PPF_SLOT_CTL 6
`define PPF_SLOT_PRESET 7
`define PPF_SLOT_DUR 8
`define PPF_SLOT_DBAND 9
`define PPF_SLOT_RUN 10
`define PPF_SLOT_MAXF 11
`define PPF_NUM_SLOTS 12
`define PPF_OWN_SLOT0 4'hA
// reset values
`define PPF_RST_KEYPAD 16'h01F4
`define PPF_RST_RAMP 16'h0064
`define PPF_RST_SRC 16'h0002
`define PPF_RST_FILT 16'h000A
`define PPF_RST_GAIN 16'h0064
`define PPF_RST_RANGE 16'h03E8
`define PPF_RST_CTL 16'h0100
`define PPF_RST_PRESET 16'h03E8
`define PPF_RST_DUR 16'h0000
`define PPF_RST_DBAND 16'h0000
`define PPF_RST_RUN 16'h0000
`define PPF_RST_MAXF 16'h1388
// fields and scales
`define PPF_RUN_BIT 0
`define PPF_DIR_BIT 0
`define PPF_DERIV_BIT 12
`define PPF_SRC_TERM 4'h8
`define PPF_SRC_LAST 4'h9
`define PPF_FULL 16'h03E8
`define PPF_GAIN_UNIT 32'h0000_0064
`define PPF_RANGE_UNIT 32'h0000_03E8
`define PPF_INT_SHIFT 3
// timing
`define PPF_CLK_NS 40
`define PPF_RAMP_UNIT_NS 10000
`define PPF_FILT_TICK_NS 1000000
`define PPF_PRESET_TICK_NS 100000000
`define PPF_RAMP_CYC ((`PPF_RAMP_UNIT_NS + `PPF_CLK_NS - 1) / `PPF_CLK_NS)
`endif

// File: src/ppf_lowpass.sv
// Purpose: first-order low-pass on the selected feedback
// Assumes: tick is one cycle every millisecond, tau in milliseconds
// Notes: 16.16 accumulator, tau of zero passes the input straight
`timescale 1ns/1ps
module ppf_lowpass import ppf_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire ppf_word_t tau,
  input wire ppf_word_t x,
  output ppf_word_t y
);
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic signed [32:0] diff;
  logic signed [32:0] step;

  // one euler step per tick: y += (x - y) / tau
  assign diff = $signed({1'b0, x, 16'h0000}) - $signed({1'b0, acc_q});
  assign step = diff / $signed({17'h00000, tau});
  assign acc_d = (tau == 16'h0000) ? {x, 16'h0000} : 32'($signed({1'b0, acc_q}) + step);
  assign y = acc_q[31:16];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= 32'h0000_0000;
    end else if (tick) begin
      acc_q <= acc_d;
    end
  end
endmodule : ppf_lowpass

// File: src/ppf_pkg.sv
// Purpose: shared types of the feedback path
// Assumes: ppf_consts.svh holds the numbers
// Notes: reset table is ordered by storage slot
`include "ppf_consts.svh"
package ppf_pkg;
  typedef enum logic [1:0] {PPF_IDLE, PPF_PRESET, PPF_REGULATE} ppf_phase_t;
  typedef logic [15:0] ppf_word_t;
  localparam ppf_word_t PPF_RST [`PPF_NUM_SLOTS] = '{`PPF_RST_KEYPAD, `PPF_RST_RAMP, `PPF_RST_SRC,
    `PPF_RST_FILT, `PPF_RST_GAIN, `PPF_RST_RANGE, `PPF_RST_CTL, `PPF_RST_PRESET, `PPF_RST_DUR,
    `PPF_RST_DBAND, `PPF_RST_RUN, `PPF_RST_MAXF};
endpackage : ppf_pkg

// File: src/ppf_top.sv
// Purpose: process regulator front end: feedback select, filter, gain, setpoint ramp, run control
// Assumes: one clock REF_CLK at 25 MHz, sync active-low reset, APB slave with word registers
// Notes: feedback inputs come from logic on REF_CLK; terminal pins are synchronised
`timescale 1ns/1ps
`include "ppf_consts.svh"
module ppf_top import ppf_pkg::*; #(
  parameter int unsigned FILT_TICK_CYC = `PPF_FILT_TICK_NS / `PPF_CLK_NS,
  parameter int unsigned PRESET_TICK_CYC = `PPF_PRESET_TICK_NS / `PPF_CLK_NS
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [15:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] KNOB_VALUE,
  input wire logic [15:0] ANALOG_INPUT_ONE,
  input wire logic [15:0] ANALOG_INPUT_TWO,
  input wire logic [15:0] PULSE_TRAIN_INPUT,
  input wire logic [15:0] LINK_VALUE,
  input wire logic [15:0] CARD_VALUE,
  input wire logic [15:0] ACTIVE_CURRENT,
  input wire logic [2:0] TERM_SEL,
  output logic [15:0] PID_OUT,
  output logic [15:0] FREQ_REF,
  output logic [15:0] FB_DISPLAY,
  output logic [15:0] DERIV_TERM,
  output logic PRESET_ACTIVE,
  output logic HOLD_ACTIVE
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  ppf_word_t regs_q [`PPF_NUM_SLOTS];
  logic [2:0] term_s1_q, term_s2_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  ppf_word_t fb_pick_q, fb_gain_q, disp_q, sp_q, freq_q, deriv_q, prev_q;
  ppf_word_t out_q, out_d, left_q, left_d;
  logic [23:0] ramp_cnt_q, ms_cnt_q, pre_cnt_q;
  ppf_phase_t phase_q, phase_d;
  logic run_q, hold_q, ms_tick_q;
  logic preset_q;
  ppf_word_t fb_filt;

  // terminal pins: two flops before any use
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      term_s1_q <= 3'h0;
      term_s2_q <= 3'h0;
    end else begin
      term_s1_q <= TERM_SEL;
      term_s2_q <= term_s1_q;
    end
  end

  // address decode; low address bits ignored, words are aligned
  wire [13:0] widx = PADDR[15:2];
  wire in_low = (widx >= `PPF_IDX_KEYPAD) && (widx <= `PPF_IDX_DBAND);
  wire in_own = (widx == `PPF_IDX_RUN) || (widx == `PPF_IDX_MAXF);
  wire is_stat = (widx == `PPF_IDX_STAT);
  wire [3:0] slot = in_low ? 4'(widx - `PPF_IDX_KEYPAD) : 4'(4'(widx - `PPF_IDX_RUN) + `PPF_OWN_SLOT0);
  wire mapped = in_low | in_own | is_stat;
  wire setup = PSEL & ~PENABLE;
  wire wr_fire = PSEL & PENABLE & pready_q & PWRITE & (in_low | in_own);
  wire [15:0] stat_word = {3'h0, hold_q, phase_q, out_q[9:0]};
  wire [15:0] rd_word = is_stat ? stat_word : ((in_low | in_own) ? regs_q[slot] : 16'h0000);

  // register storage, one flop word per slot
  for (genvar g = 0; g < `PPF_NUM_SLOTS; g++) begin : g_reg
    always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
        regs_q[g] <= PPF_RST[g];
      end else if (wr_fire && slot == 4'(g)) begin
        regs_q[g] <= PWDATA[15:0];
      end
    end
  end

  // answer prepared in setup, so every access completes in its first cycle
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup) begin
        prdata_q <= {16'h0000, rd_word};
      end
    end
  end
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;

  // feedback channel choice; the terminal code reuses channels 0..7
  wire [3:0] src_raw = regs_q[`PPF_SLOT_SRC][3:0];
  wire [3:0] eff_src = (src_raw == `PPF_SRC_TERM) ? {1'b0, term_s2_q} : src_raw;
  wire [15:0] fb_cand [10];
  assign fb_cand[0] = regs_q[`PPF_SLOT_KEYPAD];
  assign fb_cand[1] = KNOB_VALUE;
  assign fb_cand[2] = ANALOG_INPUT_ONE;
  assign fb_cand[3] = ANALOG_INPUT_TWO;
  assign fb_cand[4] = 16'h0000;
  assign fb_cand[5] = PULSE_TRAIN_INPUT;
  assign fb_cand[6] = LINK_VALUE;
  assign fb_cand[7] = CARD_VALUE;
  assign fb_cand[8] = 16'h0000;
  assign fb_cand[9] = ACTIVE_CURRENT;
  wire [15:0] fb_pick = (eff_src <= `PPF_SRC_LAST) ? fb_cand[eff_src] : 16'h0000;

  // millisecond tick paces filter, derivative and regulation
  wire ms_wrap = (ms_cnt_q == 24'(FILT_TICK_CYC - 1));
  ppf_lowpass u_filt (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .tick(ms_tick_q),
    .tau(regs_q[`PPF_SLOT_FILT]),
    .x(fb_pick_q),
    .y(fb_filt)
  );

  // gain in 0.01 steps, saturated so a large gain cannot wrap
  wire [31:0] gain_prod = 32'(fb_filt * regs_q[`PPF_SLOT_GAIN]) / `PPF_GAIN_UNIT;
  wire [15:0] fb_gain = (gain_prod > 32'h0000_FFFF) ? 16'hFFFF : gain_prod[15:0];
  // display scaling only; nothing downstream reads it
  wire [31:0] disp_prod = 32'(fb_gain_q * regs_q[`PPF_SLOT_RANGE]) / `PPF_RANGE_UNIT;
  wire [15:0] disp_w = (disp_prod > 32'h0000_FFFF) ? 16'hFFFF : disp_prod[15:0];

  // setpoint ramp: one 0.1 % step every ramp_time * 10 us
  wire [15:0] sp_tgt = regs_q[`PPF_SLOT_KEYPAD];
  wire [23:0] ramp_lim = 24'(regs_q[`PPF_SLOT_RAMP] * 24'(`PPF_RAMP_CYC));
  wire ramp_step = (ramp_cnt_q >= ramp_lim - 24'h1);

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sp_q <= 16'h0000;
      ramp_cnt_q <= 24'h0;
    end else if (regs_q[`PPF_SLOT_RAMP] == 16'h0000 || sp_q == sp_tgt) begin
      sp_q <= (regs_q[`PPF_SLOT_RAMP] == 16'h0000) ? sp_tgt : sp_q;
      ramp_cnt_q <= 24'h0;
    end else if (ramp_step) begin
      sp_q <= (sp_q < sp_tgt) ? sp_q + 16'h1 : sp_q - 16'h1;
      ramp_cnt_q <= 24'h0;
    end else begin
      ramp_cnt_q <= ramp_cnt_q + 24'h1;
    end
  end

  // deviation with direction folded in, so positive always means raise
  wire dir_neg = regs_q[`PPF_SLOT_CTL][`PPF_DIR_BIT];
  wire signed [17:0] dev_pos = $signed({2'b00, sp_q}) - $signed({2'b00, fb_gain_q});
  wire signed [17:0] dev = dir_neg ? -dev_pos : dev_pos;
  wire [17:0] dev_mag = dev[17] ? 18'(-dev) : 18'(dev);
  wire in_band = (dev_mag <= {2'b00, regs_q[`PPF_SLOT_DBAND]});
  wire signed [18:0] out_sum = $signed({3'b000, out_q}) + ($signed({dev[17], dev}) >>> `PPF_INT_SHIFT);
  wire [15:0] out_step = out_sum[18] ? 16'h0000 : ((out_sum > $signed({3'b000, `PPF_FULL})) ? `PPF_FULL
                         : out_sum[15:0]);
  wire [15:0] deriv_src = regs_q[`PPF_SLOT_CTL][`PPF_DERIV_BIT] ? fb_gain_q : dev[15:0];
  wire [15:0] preset_sat = (regs_q[`PPF_SLOT_PRESET] > `PPF_FULL) ? `PPF_FULL : regs_q[`PPF_SLOT_PRESET];
  wire run = regs_q[`PPF_SLOT_RUN][`PPF_RUN_BIT];
  wire run_rise = run & ~run_q;
  wire pre_tick = (pre_cnt_q == 24'(PRESET_TICK_CYC - 1));
  wire [31:0] freq_prod = 32'(out_q * regs_q[`PPF_SLOT_MAXF]) / {16'h0000, `PPF_FULL};

  // run phases: idle, preset hold, closed loop
  always_comb begin
    phase_d = phase_q;
    out_d = out_q;
    left_d = left_q;
    unique case (phase_q)
      PPF_IDLE: begin
        if (run_rise) begin
          out_d = preset_sat;
          left_d = regs_q[`PPF_SLOT_DUR];
          phase_d = (regs_q[`PPF_SLOT_DUR] == 16'h0000) ? PPF_REGULATE : PPF_PRESET;
        end
      end
      PPF_PRESET: begin
        if (pre_tick) begin
          left_d = left_q - 16'h1;
          phase_d = (left_q == 16'h0001) ? PPF_REGULATE : PPF_PRESET;
        end
      end
      PPF_REGULATE: begin
        if (ms_tick_q && !in_band) begin
          out_d = out_step;
        end
      end
    endcase
    if (!run) begin
      phase_d = PPF_IDLE;
      out_d = 16'h0000;
    end
  end

  // timers and control state
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      phase_q <= PPF_IDLE;
      out_q <= 16'h0000;
      left_q <= 16'h0000;
      run_q <= 1'b0;
      ms_cnt_q <= 24'h0;
      ms_tick_q <= 1'b0;
      pre_cnt_q <= 24'h0;
      preset_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      out_q <= out_d;
      left_q <= left_d;
      run_q <= run;
      ms_cnt_q <= ms_wrap ? 24'h0 : ms_cnt_q + 24'h1;
      ms_tick_q <= ms_wrap;
      pre_cnt_q <= (phase_q != PPF_PRESET || pre_tick) ? 24'h0 : pre_cnt_q + 24'h1;
      preset_q <= (phase_d == PPF_PRESET); // registered so the pin shows no decode glitches
    end
  end

  // data path stages
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      fb_pick_q <= 16'h0000;
      fb_gain_q <= 16'h0000;
      disp_q <= 16'h0000;
      freq_q <= 16'h0000;
      deriv_q <= 16'h0000;
      prev_q <= 16'h0000;
      hold_q <= 1'b0;
    end else begin
      fb_pick_q <= fb_pick;
      fb_gain_q <= fb_gain;
      disp_q <= disp_w;
      freq_q <= freq_prod[15:0];
      hold_q <= in_band & (phase_q == PPF_REGULATE);
      if (ms_tick_q) begin
        deriv_q <= deriv_src - prev_q;
        prev_q <= deriv_src;
      end
    end
  end

  assign PID_OUT = out_q;
  assign FREQ_REF = freq_q;
  assign FB_DISPLAY = disp_q;
  assign DERIV_TERM = deriv_q;
  assign PRESET_ACTIVE = preset_q;
  assign HOLD_ACTIVE = hold_q;

  a_ramp_rate: assert property (regs_q[1] != 16'h0 && $stable(regs_q[1]) |=>
    (sp_q == $past(sp_q) || sp_q == $past(sp_q) + 16'h1 || sp_q == $past(sp_q) - 16'h1))
    else $error("setpoint jumped while ramping");
  a_ramp_zero: assert property (regs_q[1] == 16'h0 |=> sp_q == $past(regs_q[0]))
    else $error("zero ramp time did not jump");
  a_src_reserved: assert property (regs_q[2][3:0] == 4'h4 |=> fb_pick_q == 16'h0)
    else $error("reserved source not zero");
  a_term_pick: assert property (regs_q[2][3:0] == 4'h8 && term_s2_q == 3'h2 |=>
    fb_pick_q == $past(ANALOG_INPUT_ONE)) else $error("terminal code chose wrong channel");
  a_keypad_pick: assert property (regs_q[2][3:0] == 4'h0 |=> fb_pick_q == $past(regs_q[0]))
    else $error("keypad value not selected");
  a_filter_pass: assert property (regs_q[3] == 16'h0 && ms_tick_q |=> fb_filt == $past(fb_pick_q))
    else $error("zero filter time did not pass input");
  a_gain_unity: assert property (regs_q[4] == 16'h0064 |=> fb_gain_q == $past(fb_filt))
    else $error("unity gain changed feedback");
  a_dir_pos: assert property (phase_q == PPF_REGULATE && run && ms_tick_q && !in_band && !dir_neg &&
    fb_gain_q > sp_q && out_q != 16'h0 && dev_mag >= 18'h8 |=> out_q < $past(out_q))
    else $error("high feedback did not lower output");
  a_band_hold: assert property (phase_q == PPF_REGULATE && in_band && run |=> out_q == $past(out_q))
    else $error("output moved inside dead band");
  a_preset_hold: assert property (phase_q == PPF_PRESET && run |=> out_q == $past(out_q))
    else $error("preset output not held");
  a_clamp_out: assert property (out_q <= `PPF_FULL)
    else $error("output above full scale");
  a_freq_map: assert property (out_q == `PPF_FULL && $stable(out_q) && $stable(regs_q[11]) |=>
    FREQ_REF == $past(regs_q[11])) else $error("full output not at max frequency");
  a_deriv_fb: assert property (ms_tick_q && regs_q[6][12] |=>
    deriv_q == 16'($past(fb_gain_q) - $past(prev_q))) else $error("derivative not on feedback");
endmodule : ppf_top
